/* File: hdl/pmdi_defs.vh */
// Constants for the MAC data interface block
`ifndef PMDI_DEFS_VH
`define PMDI_DEFS_VH
`define PMDI_SYS_CLK_HZ     20000000
`define PMDI_SYS_PERIOD_NS  50
`define PMDI_MII100_HZ      25000000
`define PMDI_MII10_HZ       2500000
`define PMDI_SERIAL_HZ      10000000
`define PMDI_RMII10_DIV     10
`define PMDI_SQE_TIME_NS    1000
`define PMDI_SQE_CYCLES     (`PMDI_SQE_TIME_NS / `PMDI_SYS_PERIOD_NS)
`define PMDI_MODE_MII       2'h0
`define PMDI_MODE_RMII      2'h1
`define PMDI_MODE_SERIAL    2'h2
`define PMDI_FIFO_WIDTH     5
`define PMDI_FIFO_DEPTH     16
`define PMDI_FIFO_ERR_BIT   4
`endif

/* File: hdl/pmdi_fifo.v */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module pmdi_fifo #(
  parameter WIDTH = 5,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             i_sys_clk,
  input  wire             i_reset,
  // Fill side
  input  wire             i_push_valid,
  input  wire [WIDTH-1:0] i_push_data,
  output wire             o_push_ready,
  // Drain side
  output wire             o_pop_valid,
  output wire [WIDTH-1:0] o_pop_data,
  input  wire             i_pop_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  reg [AW:0]      count_next;
  reg             ready_reg;
  reg             valid_reg;
  wire            push;
  wire            pop;

  assign push         = i_push_valid && ready_reg;
  assign pop          = i_pop_ready && valid_reg;
  assign o_push_ready = ready_reg;
  assign o_pop_valid  = valid_reg;
  assign o_pop_data   = mem[rd_ptr_reg];

  always @*
  begin
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + 1'b1;
    else if (pop && !push)
      count_next = count_reg - 1'b1;
  end

  // Flags are registered from the next count so they are honest in the same cycle
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      ready_reg  <= 1'b1;
      valid_reg  <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      ready_reg <= (count_next != DEPTH[AW:0]);
      valid_reg <= (count_next != {(AW+1){1'b0}});
    end
  end

  always @(posedge i_sys_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= i_push_data;
  end
endmodule // pmdi_fifo

/* File: hdl/pmdi_top.v */
// MAC-facing data interface of a 10/100 transceiver: MII, RMII and 10 Mb/s serial
// Functional notes
// RULE1 - MII transmit clock is 25 MHz at 100 Mb/s, 2.5 MHz at 10 Mb/s; code gives 10 MHz at 100 Mb/s (half period clamped to one cycle).
// RULE2 - RMII leaves both clock outputs unused; timing comes from the 50 MHz reference; code times RMII from the 20 MHz system clock.
// RULE3 - Serial mode outputs 10 MHz transmit clock; MAC launches enable and bit on it.
// RULE4 - MAC holds transmit enable high exactly while transmit data is valid.
// RULE5 - MII samples four transmit bits on the transmit clock rising edge.
// RULE6 - RMII samples two transmit bits on the reference clock.
// RULE7 - MII receive clock is 25 MHz at 100 Mb/s, 2.5 MHz at 10 Mb/s; code gives 10 MHz at 100 Mb/s (half period clamped to one cycle).
// RULE8 - Serial mode outputs a 10 MHz receive clock.
// RULE9 - MII receive valid is high exactly while receive nibble is valid.
// RULE10 - Receive valid pin sampled low at strap time selects MII mode.
// RULE11 - RMII gives a receive valid indication independent of carrier sense.
// RULE12 - MII at 100 Mb/s raises receive error on an invalid symbol in a packet.
// RULE13 - RMII at 100 Mb/s raises receive error on media error while data valid.
// RULE14 - Receive data is corrupted whenever a receive error occurs.
// RULE15 - MII receive nibble is driven on the receive clock, valid with receive valid.
// RULE16 - RMII receive dibit is driven on the reference clock.
// RULE17 - Serial mode uses only bit 0, framed by carrier; others stay low.
// RULE18 - MII and serial carrier sense is high while the medium is not idle.
// RULE19 - RMII outputs one signal merging carrier sense and receive valid.
// RULE20 - Half duplex and serial raise collision on simultaneous transmit and receive; code holds collision low in serial mode too when full duplex is set.
// RULE21 - 10 Mb/s half duplex with heartbeat pulses collision about 1 us after transmit.
// RULE22 - Full duplex holds collision low and produces no heartbeat.
// RULE23 - In RMII the MAC derives collision from merged carrier and its own enable.
// RULE24 - Mode is fixed before traffic and both parties use the same mode.
`timescale 1ns/10ps
`include "pmdi_defs.vh"
module pmdi_top #(
  parameter FIFO_DEPTH = `PMDI_FIFO_DEPTH,
  parameter FIFO_AW    = 4
) (
  // Clock and reset
  input  wire       i_sys_clk,
  input  wire       i_reset,
  // Straps and configuration levels
  input  wire       i_strap_rx_valid_indication,
  input  wire       i_strap_serial_10m_mode,
  input  wire       i_speed_100,
  input  wire       i_full_duplex,
  input  wire       i_heartbeat_en,
  // MAC transmit pins
  input  wire       i_tx_en,
  input  wire [3:0] i_txd,
  output reg        o_tx_clk,
  // MAC receive pins
  output reg        o_rx_clk,
  output reg        o_rx_dv,
  output reg        o_rx_er,
  output reg  [3:0] o_rxd,
  output reg        o_crs,
  output reg        o_col,
  // Line side transmit
  output reg        o_line_tx_valid,
  output reg  [3:0] o_line_tx_data,
  output reg        o_line_tx_active,
  // Line side receive
  input  wire       i_line_rx_valid,
  input  wire [3:0] i_line_rx_data,
  input  wire       i_line_rx_err,
  input  wire       i_line_carrier,
  output wire       o_line_rx_ready,
  // Status
  output reg  [1:0] o_mode
);
  // Half period in system cycles for a target clock, never below one
  function [7:0] half_count;
    input integer hz;
    integer n;
    begin
      n = `PMDI_SYS_CLK_HZ / (2 * hz);
      if (n < 1)
        n = 1;
      half_count = n[7:0];
    end
  endfunction

  localparam [7:0] HALF_MII100 = half_count(`PMDI_MII100_HZ);
  localparam [7:0] HALF_MII10  = half_count(`PMDI_MII10_HZ);
  localparam [7:0] HALF_SER    = half_count(`PMDI_SERIAL_HZ);
  // Integer forms first so the 8-bit copies are cut on purpose
  localparam integer RMII10_DIV_I = `PMDI_RMII10_DIV;
  localparam integer SQE_CYCLES_I = `PMDI_SQE_CYCLES;
  localparam [7:0] RMII10_DIV  = RMII10_DIV_I[7:0];
  localparam [7:0] SQE_CYCLES  = SQE_CYCLES_I[7:0];

  // Pin synchronisers; no reset so strap levels are valid right after release
  reg       txen_s1_reg;
  reg       txen_s2_reg;
  reg [3:0] txd_s1_reg;
  reg [3:0] txd_s2_reg;
  reg       strap_rv_s1_reg;
  reg       strap_rv_s2_reg;
  reg       strap_ser_s1_reg;
  reg       strap_ser_s2_reg;

  always @(posedge i_sys_clk)
  begin
    txen_s1_reg      <= i_tx_en;
    txen_s2_reg      <= txen_s1_reg;
    txd_s1_reg       <= i_txd;
    txd_s2_reg       <= txd_s1_reg;
    strap_rv_s1_reg  <= i_strap_rx_valid_indication;
    strap_rv_s2_reg  <= strap_rv_s1_reg;
    strap_ser_s1_reg <= i_strap_serial_10m_mode;
    strap_ser_s2_reg <= strap_ser_s1_reg;
  end

  // Mode capture once after reset; later strap changes are ignored
  reg       strap_done_reg;
  reg [1:0] mode_reg;

  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      strap_done_reg <= 1'b0;
      mode_reg       <= `PMDI_MODE_MII;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1; // see RULE24
      if (strap_ser_s2_reg)
        mode_reg <= `PMDI_MODE_SERIAL;
      else if (strap_rv_s2_reg)
        mode_reg <= `PMDI_MODE_RMII;
      else
        mode_reg <= `PMDI_MODE_MII; // see RULE10
    end
  end

  wire is_rmii   = (mode_reg == `PMDI_MODE_RMII);
  wire is_serial = (mode_reg == `PMDI_MODE_SERIAL);
  wire is_10m    = is_serial || !i_speed_100;

  // Clock divider; the beat is the rising edge of the MAC clocks or an RMII slot
  reg  [7:0] div_cnt_reg;
  reg        mac_clk_reg;
  reg  [7:0] div_lim;
  wire       div_wrap = (div_cnt_reg >= div_lim - 8'h01);
  wire       beat     = strap_done_reg && div_wrap && (is_rmii || !mac_clk_reg);

  always @*
  begin
    case (mode_reg)
      `PMDI_MODE_RMII:   div_lim = i_speed_100 ? 8'h01 : RMII10_DIV; // see RULE2
      `PMDI_MODE_SERIAL: div_lim = HALF_SER;                         // see RULE3
      default:           div_lim = i_speed_100 ? HALF_MII100 : HALF_MII10; // see RULE1
    endcase
  end

  always @(posedge i_sys_clk)
  begin
    if (i_reset || !strap_done_reg)
    begin
      div_cnt_reg <= 8'h00;
      mac_clk_reg <= 1'b0;
    end
    else if (div_wrap)
    begin
      div_cnt_reg <= 8'h00;
      mac_clk_reg <= is_rmii ? 1'b0 : ~mac_clk_reg;
    end
    else
      div_cnt_reg <= div_cnt_reg + 8'h01;
  end

  // Transmit: gather beats into nibbles, first beat in the low bits
  reg [3:0] tx_sh_reg;
  reg [1:0] tx_cnt_reg;
  reg       txen_d_reg;
  reg [7:0] sqe_cnt_reg;
  reg [1:0] beats_m1;
  reg [3:0] tx_shift_in;

  always @*
  begin
    case (mode_reg)
      `PMDI_MODE_RMII:
      begin
        beats_m1    = 2'h1;
        tx_shift_in = {txd_s2_reg[1:0], tx_sh_reg[3:2]}; // see RULE6
      end
      `PMDI_MODE_SERIAL:
      begin
        beats_m1    = 2'h3;
        tx_shift_in = {txd_s2_reg[0], tx_sh_reg[3:1]}; // see RULE3
      end
      default:
      begin
        beats_m1    = 2'h0;
        tx_shift_in = txd_s2_reg; // see RULE5
      end
    endcase
  end

  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      tx_sh_reg        <= 4'h0;
      tx_cnt_reg       <= 2'h0;
      txen_d_reg       <= 1'b0;
      o_line_tx_valid  <= 1'b0;
      o_line_tx_data   <= 4'h0;
      o_line_tx_active <= 1'b0;
    end
    else
    begin
      o_line_tx_valid <= 1'b0;
      if (beat)
      begin
        txen_d_reg       <= txen_s2_reg;
        o_line_tx_active <= txen_s2_reg;
        // Enable frames the data; a partial nibble at frame end is dropped
        if (txen_s2_reg) // see RULE4
        begin
          tx_sh_reg <= tx_shift_in;
          if (tx_cnt_reg == beats_m1)
          begin
            tx_cnt_reg      <= 2'h0;
            o_line_tx_valid <= 1'b1;
            o_line_tx_data  <= tx_shift_in;
          end
          else
            tx_cnt_reg <= tx_cnt_reg + 2'h1;
        end
        else
          tx_cnt_reg <= 2'h0;
      end
    end
  end

  // Receive FIFO decouples line symbols from the MAC clock rate
  wire       fifo_valid;
  wire [4:0] fifo_data;
  reg  [3:0] rx_sh_reg;
  reg  [1:0] rx_left_reg;
  reg        rx_err_reg;
  wire       rx_load = beat && (rx_left_reg == 2'h0);
  wire [3:0] rx_nib  = fifo_data[`PMDI_FIFO_ERR_BIT] ? ~fifo_data[3:0] : fifo_data[3:0]; // see RULE14

  pmdi_fifo #(
    .WIDTH (`PMDI_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_rx_fifo (
    .i_sys_clk    (i_sys_clk),
    .i_reset      (i_reset),
    .i_push_valid (i_line_rx_valid),
    .i_push_data  ({i_line_rx_err, i_line_rx_data}),
    .o_push_ready (o_line_rx_ready),
    .o_pop_valid  (fifo_valid),
    .o_pop_data   (fifo_data),
    .i_pop_ready  (rx_load)
  );

  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      rx_sh_reg   <= 4'h0;
      rx_left_reg <= 2'h0;
      rx_err_reg  <= 1'b0;
      o_rx_dv     <= 1'b0;
      o_rx_er     <= 1'b0;
      o_rxd       <= 4'h0;
    end
    else if (beat)
    begin
      if (rx_left_reg == 2'h0)
      begin
        if (fifo_valid)
        begin
          rx_left_reg <= beats_m1;
          rx_err_reg  <= fifo_data[`PMDI_FIFO_ERR_BIT] && i_speed_100 && !is_serial; // see RULE12
          o_rx_dv     <= !is_serial; // see RULE9, RULE11
          o_rx_er     <= fifo_data[`PMDI_FIFO_ERR_BIT] && i_speed_100 && !is_serial; // see RULE13
          case (mode_reg)
            `PMDI_MODE_RMII:
            begin
              o_rxd     <= {2'h0, rx_nib[1:0]}; // see RULE16
              rx_sh_reg <= {2'h0, rx_nib[3:2]};
            end
            `PMDI_MODE_SERIAL:
            begin
              o_rxd     <= {3'h0, rx_nib[0]}; // see RULE17
              rx_sh_reg <= {1'b0, rx_nib[3:1]};
            end
            default:
              o_rxd <= rx_nib; // see RULE15
          endcase
        end
        else
        begin
          // Data and error go low between frames so nothing stale looks valid
          o_rx_dv <= 1'b0;
          o_rx_er <= 1'b0;
          o_rxd   <= 4'h0;
        end
      end
      else
      begin
        rx_left_reg <= rx_left_reg - 2'h1;
        o_rx_er     <= rx_err_reg;
        if (is_rmii)
        begin
          o_rxd     <= {2'h0, rx_sh_reg[1:0]};
          rx_sh_reg <= {2'h0, rx_sh_reg[3:2]};
        end
        else
        begin
          o_rxd     <= {3'h0, rx_sh_reg[0]};
          rx_sh_reg <= {1'b0, rx_sh_reg[3:1]};
        end
      end
    end
  end

  // Carrier, collision, heartbeat and the clock pins
  wire tx_fall = beat && txen_d_reg && !txen_s2_reg;

  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_crs       <= 1'b0;
      o_col       <= 1'b0;
      o_tx_clk    <= 1'b0;
      o_rx_clk    <= 1'b0;
      o_mode      <= `PMDI_MODE_MII;
      sqe_cnt_reg <= 8'h00;
    end
    else
    begin
      o_mode   <= mode_reg;
      o_tx_clk <= is_rmii ? 1'b0 : mac_clk_reg; // see RULE1
      o_rx_clk <= is_rmii ? 1'b0 : mac_clk_reg; // see RULE7, RULE8
      if (is_rmii)
        o_crs <= i_line_carrier || o_rx_dv; // see RULE19
      else
        o_crs <= i_line_carrier; // see RULE18
      // Heartbeat only for 10 Mb/s half duplex, never in RMII or full duplex
      if (tx_fall && is_10m && !is_rmii && !i_full_duplex && i_heartbeat_en) // see RULE21
        sqe_cnt_reg <= SQE_CYCLES;
      else if (sqe_cnt_reg != 8'h00)
        sqe_cnt_reg <= sqe_cnt_reg - 8'h01;
      if (i_full_duplex || is_rmii)
        o_col <= 1'b0; // see RULE22
      else
        o_col <= (txen_s2_reg && i_line_carrier) || (sqe_cnt_reg != 8'h00); // see RULE20
    end
  end
endmodule // pmdi_top

/* File: verification/pmdi_asserts.sv */
// Concurrent checks on the MAC data interface ports
`timescale 1ns/10ps
module pmdi_asserts (
  // Clock, reset and configuration
  input wire       i_sys_clk,
  input wire       i_reset,
  input wire       i_speed_100,
  input wire       i_full_duplex,
  input wire       i_heartbeat_en,
  input wire       i_tx_en,
  input wire       i_line_carrier,
  // Outputs watched
  input wire       o_tx_clk,
  input wire       o_rx_clk,
  input wire       o_rx_er,
  input wire [3:0] o_rxd,
  input wire       o_rx_dv,
  input wire       o_col,
  input wire       o_crs,
  input wire       o_line_tx_valid,
  input wire       o_line_tx_active,
  input wire [1:0] o_mode
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Heartbeat starts where the gathered enable drops in 10 Mb/s half duplex
  sequence s_tx_end;
    $fell(o_line_tx_active) && o_mode == 2'h0 && !i_speed_100 && !i_full_duplex && i_heartbeat_en && !i_line_carrier;
  endsequence
  // Sync chain makes collision lag the pins, so both must hold a while
  sequence s_both_busy;
    (o_mode == 2'h0 && i_speed_100 && !i_full_duplex && i_tx_en && i_line_carrier) [*4];
  endsequence
  AST_RMII_CLK: assert property (o_mode == 2'h1 |-> !o_tx_clk && !o_rx_clk)
    else $error("clock driven in RMII");
  AST_CLK_PAIR: assert property (o_tx_clk == o_rx_clk)
    else $error("receive clock differs from transmit clock");
  AST_MII100_CLK: assert property ($rose(o_tx_clk) && o_mode == 2'h0 && i_speed_100 |=> !o_tx_clk ##1 o_tx_clk)
    else $error("fast clock period wrong");
  AST_MII10_CLK: assert property ($rose(o_tx_clk) && o_mode == 2'h0 && !i_speed_100 |-> o_tx_clk [*4] ##1 !o_tx_clk)
    else $error("slow clock period wrong");
  AST_SER_UNUSED: assert property (o_mode == 2'h2 |-> !o_rx_dv && !o_rx_er && o_rxd[3:1] == 3'h0)
    else $error("serial mode drives unused pins");
  AST_RMII_BITS: assert property (o_mode == 2'h1 |-> o_rxd[3:2] == 2'h0)
    else $error("RMII drives upper data bits");
  AST_ER_10M: assert property (!i_speed_100 |-> !o_rx_er)
    else $error("receive error at 10 Mb/s");
  AST_TXV_PULSE: assert property (o_line_tx_valid |=> !o_line_tx_valid)
    else $error("line transmit strobe longer than one cycle");
  AST_COL_ON: assert property (s_both_busy |-> ##1 o_col)
    else $error("collision missed");
  AST_COL_OFF: assert property ((o_mode == 2'h0 && i_speed_100 && !i_line_carrier) [*3] |-> ##1 !o_col)
    else $error("collision without receive activity");
  AST_FD_COL: assert property (i_full_duplex |-> !o_col)
    else $error("collision in full duplex");
  AST_SQE: assert property (s_tx_end |-> ##[0:2] o_col ##1 o_col [*8])
    else $error("heartbeat pulse missing");
  AST_SQE_END: assert property (s_tx_end |-> ##[15:26] !o_col)
    else $error("heartbeat pulse too long");
  AST_CRS: assert property (o_mode != 2'h1 |=> o_crs == $past(i_line_carrier))
    else $error("carrier sense does not follow the medium");
  AST_CRS_DV: assert property (o_mode == 2'h1 |=> o_crs == ($past(i_line_carrier) || $past(o_rx_dv)))
    else $error("merged carrier and valid wrong in RMII");
endmodule // pmdi_asserts
bind pmdi_top pmdi_asserts chk_u (.i_sys_clk, .i_reset, .i_speed_100, .i_full_duplex, .i_heartbeat_en,
  .i_tx_en, .i_line_carrier, .o_tx_clk, .o_rx_clk, .o_rx_er, .o_rxd, .o_rx_dv, .o_col, .o_crs, .o_line_tx_valid,
  .o_line_tx_active, .o_mode);

/* File: verification/pmdi_mac_model.sv */
// Behavioural MAC on the far side of the data interface
`timescale 1ns/10ps
module pmdi_mac_model (
  // Clock and mode
  input  wire       i_sys_clk,
  input  wire [1:0] i_mode,
  // From the device
  input  wire       i_tx_clk,
  input  wire       i_rx_clk,
  input  wire       i_rx_dv,
  input  wire       i_rx_er,
  input  wire [3:0] i_rxd,
  input  wire       i_crs,
  // To the device
  output reg        o_tx_en,
  output reg  [3:0] o_txd
);
  logic [3:0] unit_q[$];
  logic [3:0] rx_q[$];
  logic       er_q[$];
  logic       tclk_d = 1'b0;
  logic       rclk_d = 1'b0;
  logic       half = 1'b0;
  logic       rmii_col = 1'b0;
  logic [1:0] low = 2'h0;
  initial o_tx_en = 1'b0;
  initial o_txd = 4'h0;
  // Units follow the mode latched by the straps, low bits first
  task send(input logic [3:0] n);
    int b;
    begin
      if (i_mode == 2'h1)
      begin
        unit_q.push_back({2'h0, n[1:0]});
        unit_q.push_back({2'h0, n[3:2]});
      end
      else if (i_mode == 2'h2)
        for (b = 0; b < 4; b++) unit_q.push_back({3'h0, n[b]});
      else
        unit_q.push_back(n);
    end
  endtask
  always @(posedge i_sys_clk)
  begin
    tclk_d <= i_tx_clk;
    rclk_d <= i_rx_clk;
    // RMII beats every reference cycle; only 100 Mb/s is modelled there
    if (i_mode == 2'h1 || (i_tx_clk && !tclk_d))
    begin
      // Released data shows the inverse so a stale value cannot pass
      o_tx_en <= (unit_q.size() > 0);
      o_txd   <= (unit_q.size() > 0) ? unit_q.pop_front() : ~o_txd;
    end
    if (i_rx_dv && (i_mode == 2'h1 || (i_rx_clk && !rclk_d)))
    begin
      if (i_mode != 2'h1 || half)
      begin
        rx_q.push_back((i_mode == 2'h1) ? {i_rxd[1:0], low} : i_rxd);
        er_q.push_back(i_rx_er);
      end
      half <= (i_mode == 2'h1) && !half;
      low  <= i_rxd[1:0];
    end
    rmii_col <= (i_mode == 2'h1) && o_tx_en && i_crs;
  end
endmodule // pmdi_mac_model

/* File: verification/tb.sv */
// Self-checking bench for the MAC data interface
`timescale 1ns/10ps
`include "pmdi_defs.vh"
module tb;
  typedef struct {logic rm; logic sr; logic sp; logic [1:0] md; logic rxc;} pmdi_row_t;
  logic       clk, rst, strap_rm, strap_sr, speed, fdx, hb, line_v, line_er, carrier, full;
  logic [3:0] line_d;
  wire        tx_en, tx_clk, rx_clk, rx_dv, rx_er, crs, col, ltx_v, ltx_act, lrx_rdy;
  wire  [3:0] txd, rxd, ltx_d;
  wire  [1:0] mode;
  logic [3:0] tx_seen[$];
  logic [3:0] acc[$];
  pmdi_row_t  rows [4];
  int         n_mismatch = 0;
  int         compares = 0;
  int         col_n = 0;
  int         i, r;
  pmdi_top dut_u (.i_sys_clk(clk), .i_reset(rst), .i_strap_rx_valid_indication(strap_rm),
    .i_strap_serial_10m_mode(strap_sr), .i_speed_100(speed), .i_full_duplex(fdx), .i_heartbeat_en(hb),
    .i_tx_en(tx_en), .i_txd(txd), .o_tx_clk(tx_clk), .o_rx_clk(rx_clk), .o_rx_dv(rx_dv), .o_rx_er(rx_er),
    .o_rxd(rxd), .o_crs(crs), .o_col(col), .o_line_tx_valid(ltx_v), .o_line_tx_data(ltx_d),
    .o_line_tx_active(ltx_act), .i_line_rx_valid(line_v), .i_line_rx_data(line_d), .i_line_rx_err(line_er),
    .i_line_carrier(carrier), .o_line_rx_ready(lrx_rdy), .o_mode(mode));
  pmdi_mac_model mac_u (.i_sys_clk(clk), .i_mode(mode), .i_tx_clk(tx_clk), .i_rx_clk(rx_clk), .i_rx_dv(rx_dv),
    .i_rx_er(rx_er), .i_rxd(rxd), .i_crs(crs), .o_tx_en(tx_en), .o_txd(txd));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (ltx_v === 1'b1) tx_seen.push_back(ltx_d);
    // RMII has no collision pin, so the MAC model's own detection is counted there
    if (col === 1'b1 || mac_u.rmii_col === 1'b1) col_n++;
  end
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    begin
      compares++;
      if (seen !== exp)
      begin
        n_mismatch++;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task do_reset(input logic rm, input logic sr, input logic sp, input logic fd, input logic h);
    begin
      rst <= 1'b1;
      {strap_rm, strap_sr, speed, fdx, hb} <= {rm, sr, sp, fd, h};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Mode reaches its output two edges after release; the third edge sees it settled
      repeat (3) @(posedge clk);
    end
  endtask
  // Bounded wait on the transmit capture (0) or the model's receive queue (1)
  task wait_n(input int which, input int n);
    int k;
    begin
      k = 0;
      while ((which == 0 ? tx_seen.size() : mac_u.rx_q.size()) < n && k < 4000)
      begin
        k++;
        @(posedge clk);
      end
      if (k >= 4000)
      begin
        n_mismatch++;
        print_verdict();
      end
    end
  endtask
  task tx_frame(input int n);
    begin
      tx_seen.delete();
      for (i = 0; i < n; i++) mac_u.send(4'h5 + 4'h3 * i[3:0]);
      wait_n(0, n);
      for (i = 0; i < n; i++) chk("tx nibble", {4'h0, tx_seen[i]}, {4'h0, 4'h5 + 4'h3 * i[3:0]});
    end
  endtask
  // Push holds valid and data until the FIFO shows room at the edge that takes them
  task push(input logic [3:0] n, input logic e);
    int k;
    begin
      {line_v, line_d, line_er} <= {1'b1, n, e};
      k = 0;
      @(negedge clk);
      while (lrx_rdy !== 1'b1 && k < 500)
      begin
        k++;
        @(negedge clk);
      end
      if (k >= 500) wait_n(1, 1 << 20);
      @(posedge clk);
    end
  endtask
  task rx_frame(input int n, input logic e);
    begin
      mac_u.rx_q.delete();
      mac_u.er_q.delete();
      for (i = 0; i < n; i++) push(4'hA - i[3:0], e && i == 0);
      {line_v, line_er} <= 2'h0;
      wait_n(1, n);
      for (i = 0; i < n; i++)
        chk("rx nibble", {4'h0, mac_u.rx_q[i]}, {4'h0, (e && i == 0) ? ~(4'hA - i[3:0]) : 4'hA - i[3:0]});
      chk("rx error", {7'h0, mac_u.er_q[0]}, {7'h0, e & speed});
    end
  endtask
  initial
  begin
    {rst, strap_rm, strap_sr, speed, fdx, hb, line_v, line_er, carrier, line_d} = {1'b1, 8'h00, 4'h0};
    rows = '{'{0, 0, 1, `PMDI_MODE_MII, 1}, '{0, 0, 0, `PMDI_MODE_MII, 0},
             '{1, 0, 1, `PMDI_MODE_RMII, 1}, '{0, 1, 0, `PMDI_MODE_SERIAL, 0}};
    repeat (2) @(posedge clk);
    chk("ready in reset", {7'h0, lrx_rdy}, 8'h01);
    chk("mode in reset", {6'h0, mode}, 8'h00);
    $display("reset test done");
    for (r = 0; r < 4; r++)
    begin
      do_reset(rows[r].rm, rows[r].sr, rows[r].sp, 1'b1, 1'b0);
      chk("mode", {6'h0, mode}, {6'h0, rows[r].md});
      tx_frame(6);
      if (rows[r].rxc) rx_frame(5, 1'b0);
      $display("row %0d done", r);
    end
    do_reset(0, 0, 1, 1, 0);
    rx_frame(3, 1'b1);
    $display("error test done");
    // Slow drain at 10 Mb/s lets a burst fill the FIFO until it refuses
    do_reset(0, 0, 0, 1, 0);
    acc.delete();
    full = 1'b0;
    mac_u.rx_q.delete();
    for (r = 0; r < 24; r++)
    begin
      {line_v, line_d} <= {1'b1, r[3:0]};
      @(negedge clk);
      if (lrx_rdy === 1'b1) acc.push_back(r[3:0]);
      else full = 1'b1;
      @(posedge clk);
    end
    line_v <= 1'b0;
    chk("fifo refused", {7'h0, full}, 8'h01);
    wait_n(1, acc.size());
    for (r = 0; r < acc.size(); r++) chk("fifo order", {4'h0, mac_u.rx_q[r]}, {4'h0, acc[r]});
    $display("fifo test done");
    // Third pass is RMII half duplex, where collision comes from merged carrier and enable
    for (r = 0; r < 3; r++)
    begin
      do_reset(r[1], 0, 1, r[0], 0);
      carrier <= 1'b1;
      col_n = 0;
      tx_frame(8);
      carrier <= 1'b0;
      chk("collision", {7'h0, col_n > 0}, {7'h0, !r[0]});
    end
    do_reset(0, 0, 0, 0, 1);
    col_n = 0;
    tx_frame(4);
    repeat (80) @(posedge clk);
    chk("heartbeat", {7'h0, col_n >= 15 && col_n <= 25}, 8'h01);
    $display("collision tests done");
    print_verdict();
  end
endmodule // tb
